// *** line_coder_pkg.sv ***
// constants and carrier types for the bi-phase encoder
// What this block does
// - Every frame holds two subframes of 32 slots, each 64 unit intervals long.
// - A frame of 64 slots spans 128 unit intervals, two line states per slot.
// - Slots 0 to 3 of each subframe carry an eight-state preamble.
// - Preamble patterns X, Y, Z are inverted when the previous line state is 1.
// - First preamble state differs from the last state of the parity symbol.
// - First subframe uses X, or Z every 192 frames; second always uses Y.
// - Slots 4 to 27 carry the 24-bit sample, least significant bit first.
// - In 20-bit range the sample fills slots 8 to 27; slots 4 to 7 are auxiliary.
// - Unused low bits of the 20 or 24 bit audio field are sent as zero.
// - Slot 28 carries validity: 0 fit for conversion, 1 not fit.
// - Validity is 1 when buffer enable and channel control are set, or sample flag set.
// - Slot 29 carries the user bit given with the sample.
// - Slot 30 carries one status bit; 192-bit blocks start in the Z frame.
// - Slot 31 parity gives even ones and zeros over slots 4 to 31.
// - Slots 4 to 31 are bi-phase mark coded on the line.
// - Symbol: first state inverts previous; second inverts again only for a 1.
// - Subframes carry two channels, or one channel at double rate.
// - Samples arrive as 32-bit words, 192 per channel per block.
package line_coder_pkg;

    // ----------------------------------------------------------------
    // frame geometry
    // ----------------------------------------------------------------
    localparam int          SLOTS_PER_SUBFRAME = 32;
    localparam int          UI_PER_FRAME       = 128;
    localparam int          FRAMES_PER_BLOCK   = 192;
    localparam logic [6:0]  UI_LAST            = 7'h7f;
    localparam logic [7:0]  FRAME_LAST         = 8'hbf;
    localparam logic [4:0]  SLOT_AUDIO_FIRST   = 5'h04;
    localparam logic [4:0]  SLOT_AUDIO_LAST    = 5'h1b;
    localparam logic [4:0]  SLOT_VALIDITY      = 5'h1c;
    localparam logic [4:0]  SLOT_USER          = 5'h1d;
    localparam logic [4:0]  SLOT_STATUS        = 5'h1e;
    localparam logic [4:0]  SLOT_PARITY        = 5'h1f;

    // preamble patterns for a previous line state of 0, first state in bit 7
    localparam logic [7:0]  PREAMBLE_X         = 8'he2;
    localparam logic [7:0]  PREAMBLE_Y         = 8'he4;
    localparam logic [7:0]  PREAMBLE_Z         = 8'he8;

    // ----------------------------------------------------------------
    // register map (byte addresses)
    // ----------------------------------------------------------------
    localparam int          ADDR_W             = 8;
    localparam logic [7:0]  OFS_CONTROL        = 8'h00;
    localparam logic [7:0]  OFS_STATUS         = 8'h04;
    localparam logic [7:0]  OFS_CS_BASE        = 8'h20;
    localparam int          CS_WORDS_PER_CHAN  = 6;
    localparam int          CS_WORDS           = 12;
    localparam logic [7:0]  OFS_CS_LAST        = 8'h4c;
    localparam logic [4:0]  SOURCE_BITS_RESET  = 5'h18;
    localparam logic [1:0]  RESP_OKAY          = 2'h0;
    localparam logic [1:0]  RESP_SLVERR        = 2'h2;

    // control word: bits 12..8 source bits, 5 range20, 4 double rate,
    // 3 validity b, 2 validity a, 1 status buffer enable, 0 enable
    typedef struct packed {
        logic [4:0] source_bits;
        logic       range_20;
        logic       single_channel_double_rate;
        logic       validity_b;
        logic       validity_a;
        logic       status_buffer_enable;
        logic       enable;
    } transmit_control_word_t;

    // one 32-bit sample word as delivered by the source
    typedef struct packed {
        logic [1:0]  spare_hi;
        logic        user;
        logic        validity;
        logic [3:0]  spare_lo;
        logic [23:0] audio;
    } sample_word_t;

    // sample pair for one frame: channel a goes out first
    typedef struct packed {
        sample_word_t chan_b;
        sample_word_t chan_a;
    } sample_pair_t;

endpackage

// *** biphase_frame_encoder.sv ***
// bi-phase mark subframe encoder with an AXI4-Lite register slave
`timescale 1ns/10ps
module biphase_frame_encoder
(
    // clock and reset
    input  wire logic                         clk,
    input  wire logic                         reset,
    // AXI4-Lite write address and data
    input  wire logic [line_coder_pkg::ADDR_W-1:0] awaddr,
    input  wire logic                         awvalid,
    output logic                              awready,
    input  wire logic [31:0]                  wdata,
    input  wire logic [3:0]                   wstrb,
    input  wire logic                         wvalid,
    output logic                              wready,
    // AXI4-Lite write response
    output logic [1:0]                        bresp,
    output logic                              bvalid,
    input  wire logic                         bready,
    // AXI4-Lite read address and data
    input  wire logic [line_coder_pkg::ADDR_W-1:0] araddr,
    input  wire logic                         arvalid,
    output logic                              arready,
    output logic [31:0]                       rdata,
    output logic [1:0]                        rresp,
    output logic                              rvalid,
    input  wire logic                         rready,
    // sample stream from the on-chip source
    input  wire line_coder_pkg::sample_pair_t sample_data,
    input  wire logic                         sample_valid,
    output logic                              sample_ready,
    // serial line
    output logic                              line_out
);
    import line_coder_pkg::*;

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic                          awready;
        logic                          wready;
        logic                          bvalid;
        logic [1:0]                    bresp;
        logic                          aw_got;
        logic                          w_got;
        logic [ADDR_W-1:0]             waddr;
        logic [31:0]                   wdata;
        logic [3:0]                    wstrb;
        logic                          arready;
        logic                          rvalid;
        logic [1:0]                    rresp;
        logic [31:0]                   rdata;
        transmit_control_word_t        ctrl;
        logic                          underrun;
        logic [CS_WORDS-1:0][31:0]     cs;
        sample_pair_t                  pending;
        logic                          pending_full;
        logic                          sample_ready;
        sample_pair_t                  work;
        logic                          running;
        logic [6:0]                    ui;
        logic [7:0]                    frame;
        logic                          line;
        logic                          pre_level;
        logic                          parity;
    } state_t;

    state_t s;
    state_t next_s;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // merge write data into an old word under byte strobes
    function automatic logic [31:0] merge_bytes(input logic [31:0] old,
                                                input logic [31:0] data,
                                                input logic [3:0]  strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
                r[i*8 +: 8] = data[i*8 +: 8];
        end
        return r;
    endfunction

    // audio field with unused low bits cleared
    function automatic logic [23:0] audio_field(input logic [23:0] audio,
                                                input logic        range_20,
                                                input logic [4:0]  source_bits);
        logic [4:0]  width;
        logic [4:0]  zeros;
        logic [23:0] mask;
        width = range_20 ? 5'h14 : 5'h18;
        zeros = (source_bits >= width) ? 5'h00 : 5'(width - source_bits);
        mask  = ~((24'h000001 << zeros) - 24'h000001);
        // in 20-bit range the field starts at bit 4; aux bits pass untouched
        if (range_20)
            mask = {mask[19:0], 4'hf};
        return audio & mask;
    endfunction

    // register read decode
    function automatic logic [32:0] read_reg(input state_t st, input logic [ADDR_W-1:0] a);
        logic [32:0] r;
        r = {1'b0, 32'h00000000};
        if (a == OFS_CONTROL)
            r = {1'b0, 19'h00000, st.ctrl.source_bits, 2'h0, st.ctrl[5:0]};
        else if (a == OFS_STATUS)
            r = {1'b0, 15'h0000, st.running, st.frame, 7'h00, st.underrun};
        else if (a >= OFS_CS_BASE && a <= OFS_CS_LAST && a[1:0] == 2'h0)
            r = {1'b0, st.cs[4'(ADDR_W'(a - OFS_CS_BASE) >> 2)]};
        else
            r = {1'b1, 32'h00000000};
        return r;
    endfunction

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    logic [6:0]   nu;
    logic [4:0]   slot;
    logic         sub_b;
    logic         chan_b;
    sample_word_t word;
    logic [23:0]  field;
    logic         bit_val;
    logic         cs_bit;
    logic         valid_flag;
    logic [7:0]   pattern;
    logic         pre;
    logic [3:0]   cs_idx;
    logic [32:0]  rd;
    logic [31:0]  merged;

    always_comb
    begin
        next_s     = s;
        nu         = 7'(s.ui + 7'h01);
        slot       = nu[5:1];
        sub_b      = nu[6];
        chan_b     = 1'b0;
        word       = '0;
        field      = 24'h000000;
        bit_val    = 1'b0;
        cs_bit     = 1'b0;
        valid_flag = 1'b0;
        pattern    = PREAMBLE_X;
        pre        = 1'b0;
        cs_idx     = 4'h0;
        rd         = read_reg(s, araddr);
        merged     = merge_bytes({19'h00000, s.ctrl.source_bits, 2'h0, s.ctrl[5:0]}, s.wdata, s.wstrb);

        // write address and data are taken in either order
        if (awvalid && s.awready)
        begin
            next_s.aw_got = 1'b1;
            next_s.waddr  = awaddr;
        end
        if (wvalid && s.wready)
        begin
            next_s.w_got = 1'b1;
            next_s.wdata = wdata;
            next_s.wstrb = wstrb;
        end
        if (s.bvalid && bready)
            next_s.bvalid = 1'b0;

        // perform the write once both halves are held
        if (s.aw_got && s.w_got && !s.bvalid)
        begin
            next_s.aw_got = 1'b0;
            next_s.w_got  = 1'b0;
            next_s.bvalid = 1'b1;
            next_s.bresp  = RESP_OKAY;
            if (s.waddr == OFS_CONTROL)
                next_s.ctrl = {merged[12:8], merged[5:0]};
            else if (s.waddr == OFS_STATUS)
            begin
                // write one to clear the underrun flag
                if (s.wstrb[0] && s.wdata[0])
                    next_s.underrun = 1'b0;
            end
            else if (s.waddr >= OFS_CS_BASE && s.waddr <= OFS_CS_LAST && s.waddr[1:0] == 2'h0)
                next_s.cs[4'(ADDR_W'(s.waddr - OFS_CS_BASE) >> 2)] =
                    merge_bytes(s.cs[4'(ADDR_W'(s.waddr - OFS_CS_BASE) >> 2)], s.wdata, s.wstrb);
            else
                next_s.bresp = RESP_SLVERR;
        end
        next_s.awready = !next_s.aw_got && !next_s.bvalid;
        next_s.wready  = !next_s.w_got && !next_s.bvalid;

        // read channel: answer registered one edge after the address
        if (s.rvalid && rready)
            next_s.rvalid = 1'b0;
        if (arvalid && s.arready)
        begin
            next_s.rvalid = 1'b1;
            next_s.rdata  = rd[31:0];
            next_s.rresp  = rd[32] ? RESP_SLVERR : RESP_OKAY;
        end
        next_s.arready = !next_s.rvalid;

        // accept a 64-bit sample pair into the holding slot
        if (sample_valid && s.sample_ready)
        begin
            next_s.pending      = sample_data;
            next_s.pending_full = 1'b1;
        end

        if (!s.ctrl.enable)
        begin
            // idle: block restarts with Z, line state 0
            next_s.running      = 1'b0;
            next_s.ui           = UI_LAST;
            next_s.frame        = 8'h00;
            next_s.line         = 1'b0;
            next_s.pre_level    = 1'b0;
            next_s.parity       = 1'b0;
            next_s.pending_full = 1'b0;
        end
        else
        begin
            // one line state per unit interval, 128 per frame
            next_s.ui = nu;
            if (nu == 7'h00)
            begin
                // frame counter wraps every 192 frames
                if (s.running)
                    next_s.frame = (s.frame == FRAME_LAST) ? 8'h00 : 8'(s.frame + 8'h01);
                next_s.running = 1'b1;
                // load the pair at the frame boundary
                if (next_s.pending_full)
                begin
                    next_s.work         = next_s.pending;
                    next_s.pending_full = 1'b0;
                end
                else
                begin
                    // no sample ready: send silence marked not valid
                    next_s.work                = '0;
                    next_s.work.chan_a.validity = 1'b1;
                    next_s.work.chan_b.validity = 1'b1;
                    next_s.underrun            = 1'b1;
                end
            end

            // double-rate mode uses channel a controls for both subframes
            chan_b = sub_b && !s.ctrl.single_channel_double_rate;
            word   = sub_b ? next_s.work.chan_b : next_s.work.chan_a;
            // place and trim the audio field
            field  = audio_field(word.audio, s.ctrl.range_20, s.ctrl.source_bits);
            // validity from buffer control or the sample flag
            valid_flag = word.validity ||
                         (s.ctrl.status_buffer_enable && (chan_b ? s.ctrl.validity_b : s.ctrl.validity_a));
            // one status bit per subframe, bit 0 in the Z frame
            cs_idx = 4'((chan_b ? CS_WORDS_PER_CHAN : 0) + int'(next_s.frame[7:5]));
            cs_bit = s.cs[cs_idx][next_s.frame[4:0]];

            // data bit for the slot being started
            if (slot >= SLOT_AUDIO_FIRST && slot <= SLOT_AUDIO_LAST)
                bit_val = field[5'(slot - SLOT_AUDIO_FIRST)];
            else if (slot == SLOT_VALIDITY)
                bit_val = valid_flag;
            else if (slot == SLOT_USER)
                bit_val = word.user;
            else if (slot == SLOT_STATUS)
                bit_val = cs_bit;
            else
                bit_val = s.parity;

            // running parity over slots 4 to 30
            if (!nu[0])
            begin
                if (slot == SLOT_AUDIO_FIRST)
                    next_s.parity = bit_val;
                else if (slot > SLOT_AUDIO_FIRST && slot < SLOT_PARITY)
                    next_s.parity = s.parity ^ bit_val;
            end

            if (slot < SLOT_AUDIO_FIRST)
            begin
                // X or Z on subframe one, Y on subframe two
                if (sub_b)
                    pattern = PREAMBLE_Y;
                else if (next_s.frame == 8'h00)
                    pattern = PREAMBLE_Z;
                else
                    pattern = PREAMBLE_X;
                // capture the parity symbol's last state at the boundary
                pre = (nu[2:0] == 3'h0) ? s.line : s.pre_level;
                if (nu[2:0] == 3'h0)
                    next_s.pre_level = s.line;
                // eight states, inverted after a high line
                next_s.line = pattern[3'(3'h7 - nu[2:0])] ^ pre;
            end
            else if (!nu[0])
                next_s.line = !s.line;
            else
                // mid-symbol toggle only for a one
                next_s.line = bit_val ? !s.line : s.line;
        end
        // ready with the enable so that frame 0 can carry a pair
        next_s.sample_ready = !next_s.pending_full && next_s.ctrl.enable;
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            // reset: frame zero, line 0, idle
            s                  <= '0;
            s.ui               <= UI_LAST;
            s.ctrl.source_bits <= SOURCE_BITS_RESET;
        end
        else
            s <= next_s;
    end

    // outputs straight from flip-flops
    assign awready      = s.awready;
    assign wready       = s.wready;
    assign bvalid       = s.bvalid;
    assign bresp        = s.bresp;
    assign arready      = s.arready;
    assign rvalid       = s.rvalid;
    assign rdata        = s.rdata;
    assign rresp        = s.rresp;
    assign sample_ready = s.sample_ready;
    assign line_out     = s.line;

endmodule

// *** biphase_frame_encoder_monitor.sv ***
// checker for the encoder port behaviour
`timescale 1ns/10ps
module biphase_frame_encoder_monitor
(
    // clock and reset
    input wire logic        clk,
    input wire logic        reset,
    // bus handshakes
    input wire logic        awvalid,
    input wire logic        awready,
    input wire logic        wvalid,
    input wire logic        wready,
    input wire logic        bvalid,
    input wire logic        bready,
    input wire logic [1:0]  bresp,
    input wire logic        arvalid,
    input wire logic        arready,
    input wire logic        rvalid,
    // sample stream and line
    input wire logic        sample_valid,
    input wire logic        sample_ready,
    input wire logic        line_out
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    // ----------------------------------------------------------------
    // line shape
    // ----------------------------------------------------------------
    AST_RST_QUIET: assert property (disable iff (1'b0) reset |=> !line_out && !sample_ready)
        else $error("line or ready active after reset");
    AST_IDLE_Z: assert property (!line_out [*4] ##1 line_out |-> line_out [*3] ##1 !line_out ##1 line_out ##1 !line_out [*3])
        else $error("no Z after idle");
    AST_ONES_RUN: assert property (line_out [*4] |-> 1'b0)
        else $error("line high for four states");
    AST_SUBFRAME_LEN: assert property (!line_out [*4] ##1 line_out |-> ##64 $changed(line_out) ##1 $stable(line_out) [*2] ##1 $changed(line_out))
        else $error("bad subframe length");
    AST_FRAME_LEN: assert property (!line_out [*4] ##1 line_out |-> ##128 $changed(line_out) ##1 $stable(line_out) [*2] ##1 $changed(line_out))
        else $error("bad frame length");

    // ----------------------------------------------------------------
    // handshakes
    // ----------------------------------------------------------------
    AST_SREADY_DROP: assert property (sample_valid && sample_ready ##1 sample_valid && sample_ready |=> !sample_ready)
        else $error("slot not full after two takes");
    AST_BVALID_HOLD: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped early");
    AST_BVALID_TIME: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
        else $error("write response late");
    AST_ARREADY_LOW: assert property (rvalid |-> !arready)
        else $error("arready while rvalid");

    // main scenarios
    cover property (sample_valid && sample_ready);
    cover property (bvalid && bready);
    cover property (!line_out [*4] ##1 line_out);
endmodule

bind biphase_frame_encoder biphase_frame_encoder_monitor i_biphase_frame_encoder_monitor (.clk(clk), .reset(reset),
    .awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready),
    .bresp(bresp), .arvalid(arvalid), .arready(arready), .rvalid(rvalid), .sample_valid(sample_valid),
    .sample_ready(sample_ready), .line_out(line_out));

// *** line_receiver.sv ***
// serial line receiver: finds preambles and decodes bi-phase slots
`timescale 1ns/10ps
module line_receiver
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        reset,
    // serial line
    input  wire logic        line_in,
    // decoded subframe
    output logic             sub_done,
    output logic [1:0]       sub_kind,
    output logic [27:0]      sub_bits,
    output logic             code_err
);
    import line_coder_pkg::*;
    logic [8:0]  hist;
    logic [7:0]  pat;
    logic [27:0] bits;
    int          cnt;

    // preamble hunt, then 56 states of symbols
    always @(posedge clk)
    begin
        sub_done <= 1'b0;
        hist = {hist[7:0], line_in};
        pat  = hist[7:0] ^ {8{hist[8]}};
        if (reset)
        begin
            hist     = '0;
            cnt      = 0;
            code_err <= 1'b0;
        end
        else if (cnt == 0)
        begin
            if (pat == PREAMBLE_X || pat == PREAMBLE_Y || pat == PREAMBLE_Z)
            begin
                sub_kind <= (pat == PREAMBLE_X) ? 2'h0 : (pat == PREAMBLE_Y) ? 2'h1 : 2'h2;
                cnt = 1;
            end
        end
        else
        begin
            cnt = cnt + 1;
            if (cnt % 2 == 1)
            begin
                if (hist[1] == hist[2])
                    code_err <= 1'b1;
                bits = {hist[1] ^ hist[0], bits[27:1]};
            end
            if (cnt == 57)
            begin
                sub_bits <= bits;
                sub_done <= 1'b1;
                cnt = 0;
            end
        end
    end
endmodule

// *** tb.sv ***
// self-checking bench for the bi-phase subframe encoder
`timescale 1ns/10ps
module tb;
    import line_coder_pkg::*;
    typedef struct packed {
        logic [4:0]   src;
        logic [4:0]   flags;
        sample_word_t a;
        sample_word_t b;
    } row_t;
    logic                clk, reset, awvalid, wvalid, bready, arvalid, rready, sample_valid, rx_reset;
    logic                awready, wready, bvalid, arready, rvalid, sample_ready, line_out;
    logic [ADDR_W-1:0]   awaddr, araddr;
    logic [31:0]         wdata, rdata, rd;
    logic [3:0]          wstrb;
    logic [1:0]          bresp, rresp, rs, sub_kind;
    sample_pair_t        sample_data;
    logic                sub_done, code_err;
    logic [27:0]         sub_bits;
    logic [1:0]          gk[$];
    logic [27:0]         gb[$];
    row_t                rows[6];
    row_t                r;
    int                  mismatches, checks_done;

    biphase_frame_encoder i_biphase_frame_encoder (.clk(clk), .reset(reset), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
        .rresp(rresp), .rvalid(rvalid), .rready(rready), .sample_data(sample_data), .sample_valid(sample_valid),
        .sample_ready(sample_ready), .line_out(line_out));
    line_receiver i_line_receiver (.clk(clk), .reset(rx_reset), .line_in(line_out), .sub_done(sub_done),
        .sub_kind(sub_kind), .sub_bits(sub_bits), .code_err(code_err));

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            mismatches++;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        awaddr <= a; wdata <= d; wstrb <= 4'hf; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        do
        begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        rs = bresp;
        bready <= 1'b0;
    endtask

    task automatic axi_read(input logic [7:0] a);
        @(posedge clk);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        do
        begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rd = rdata;
        rs = rresp;
        rready <= 1'b0;
    endtask

    task automatic wait_subs(input int k);
        while (gk.size() < k) @(posedge clk);
        repeat (10) @(posedge clk);
    endtask

    // stop encoder, clear receiver
    task automatic restart(input logic [4:0] src, input logic [4:0] flags);
        axi_write(OFS_CONTROL, {19'h0, src, 2'h0, flags, 1'b0});
        rx_reset <= 1'b1;
        @(posedge clk);
        rx_reset <= 1'b0;
        gk.delete();
        gb.delete();
    endtask

    function automatic logic [27:0] expect_bits(sample_word_t w, logic r20, logic [4:0] src, logic vc, logic cs);
        logic [23:0] a;
        int          z;
        z = (r20 ? 20 : 24) - int'(src);
        if (z < 0) z = 0;
        a = w.audio & ~(((24'h1 << z) - 24'h1) << (r20 ? 4 : 0));
        return {^{a, w.validity | vc, w.user, cs}, cs, w.user, w.validity | vc, a};
    endfunction

    // ----------------------------------------------------------------
    // clock, watchdog, collector
    // ----------------------------------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial
    begin
        #1000000;
        mismatches++;
        finish_test();
    end

    // store every decoded subframe
    always @(posedge clk)
    begin
        if (sub_done)
        begin
            gk.push_back(sub_kind);
            gb.push_back(sub_bits);
        end
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial
    begin
        {reset, rx_reset} = 2'h3;
        {awvalid, wvalid, bready, arvalid, rready, sample_valid, awaddr, araddr, wdata, wstrb, sample_data} = '0;
        rows = '{'{5'd24, 5'h00, 32'h20a5c3e1, 32'h105a3c1e}, '{5'd20, 5'h10, 32'h00fedcba, 32'h2012345f},
                 '{5'd16, 5'h10, 32'h00ffffff, 32'h10abcdef}, '{5'd18, 5'h00, 32'h00ffffff, 32'h20800001},
                 '{5'd24, 5'h05, 32'h00000001, 32'h00000002}, '{5'd24, 5'h0b, 32'h00c00003, 32'h20000004}};
        repeat (16) @(posedge clk);
        check(line_out, 1'b0);
        check(sample_ready, 1'b0);
        reset <= 1'b0;
        rx_reset <= 1'b0;
        axi_read(OFS_CONTROL);
        check(rd, 32'h00001800);
        axi_read(8'h10);
        check(rd, 32'h0);
        check(rs, RESP_SLVERR);
        axi_write(OFS_CS_BASE, 32'h00000001);
        axi_write(OFS_CS_BASE + 8'h18, 32'h00000000);
        // table of sample words and modes
        for (int i = 0; i < 6; i++)
        begin
            r = rows[i];
            restart(r.src, r.flags);
            sample_data <= {r.b, r.a};
            sample_valid <= 1'b1;
            axi_write(OFS_CONTROL, {19'h0, r.src, 2'h0, r.flags, 1'b1});
            while (!sample_ready) @(posedge clk);
            sample_valid <= 1'b0;
            wait_subs(2);
            check(gk[0], 2'h2);
            check(gk[1], 2'h1);
            check(gb[0], expect_bits(r.a, r.flags[4], r.src, r.flags[0] & r.flags[1], 1'b1));
            check(gb[1], expect_bits(r.b, r.flags[4], r.src, r.flags[0] & (r.flags[3] ? r.flags[1] : r.flags[2]),
                                     r.flags[3]));
        end
        // a block of silence
        restart(5'd24, 5'h00);
        axi_write(OFS_CONTROL, 32'h00001801);
        wait_subs(386);
        for (int i = 0; i < 386; i++)
            check(gk[i], (i % 2) ? 2'h1 : (i == 0 || i == 384) ? 2'h2 : 2'h0);
        check(gb[0][24:0], 25'h1000000);
        axi_read(OFS_STATUS);
        check(rd[0], 1'b1);
        check(code_err, 1'b0);
        finish_test();
    end
endmodule
